// File: spm_pkg.sv
`default_nettype none
package spm_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_COMMAND = 6'h00;
	localparam logic [5:0] OFS_VSET = 6'h01;
	localparam logic [5:0] OFS_ISET = 6'h03;
	localparam logic [5:0] OFS_PSET = 6'h05;
	localparam logic [5:0] OFS_OVTH = 6'h07;
	localparam logic [5:0] OFS_ZMAX = 6'h09;
	localparam logic [5:0] OFS_ZMIN = 6'h0b;
	localparam logic [5:0] OFS_ZRISE = 6'h0d;
	localparam logic [5:0] OFS_ZFALL = 6'h0f;
	localparam logic [5:0] OFS_FSMASK = 6'h11;
	localparam logic [5:0] OFS_CZMAX = 6'h13;
	localparam logic [5:0] OFS_CDROP = 6'h15;
	localparam logic [5:0] OFS_ZIMIN = 6'h17;
	localparam logic [5:0] OFS_ZALPHA = 6'h19;
	localparam logic [5:0] OFS_DEFCMD = 6'h1b;
	localparam logic [5:0] OFS_QUERY = 6'h1c;
	localparam logic [5:0] OFS_EXPCNT = 6'h1d;
	localparam logic [5:0] OFS_RECPER = 6'h1e;
	localparam logic [5:0] OFS_VSLEW = 6'h1f;
	localparam logic [5:0] OFS_ISLEW = 6'h21;
	localparam logic [5:0] OFS_MALPHA = 6'h23;
	localparam logic [5:0] OFS_STEPMAX = 6'h25;
	localparam logic [5:0] OFS_ZDELAY = 6'h27;
	localparam logic [5:0] OFS_BUSTO = 6'h28;
	localparam logic [5:0] OFS_UNLOCK = 6'h29;
	// Own read-only status words
	localparam logic [5:0] OFS_STATUS = 6'h30;
	localparam logic [5:0] OFS_VMON = 6'h31;
	localparam logic [5:0] OFS_IMON = 6'h33;
	localparam logic [5:0] OFS_PMON = 6'h35;
	localparam logic [5:0] OFS_ZMON = 6'h37;
	localparam logic [5:0] OFS_VAPP = 6'h39;
	localparam logic [5:0] OFS_IAPP = 6'h3b;
	localparam logic [5:0] OFS_FSCALE = 6'h3d;
	localparam logic [15:0] CODE_SAVE = 16'h1234;
	localparam logic [15:0] CODE_RESTORE = 16'h5678;
	localparam logic [15:0] CODE_FACTORY = 16'h9abc;
	localparam logic [31:0] LOCK_CODE = 32'hffffffff;
	localparam int CLK_HZ = 40000000;
	localparam int SAMPLE_HZ = 125;
	localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
	localparam int SAMPLE_MS = 8;
	localparam int ALPHA_FRAC = 24;
	localparam int SLEW_FRAC = 15;
	localparam logic [31:0] ALPHA_ONE = 32'h01000000;
	localparam logic [31:0] ALPHA_MAX = 32'h00fff972;
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [15:0] RESET_HALF = 16'h0000;
	typedef struct packed {
		logic [31:0] vset;
		logic [31:0] iset;
	} spm_setpt_type;
	typedef struct packed {
		logic [31:0] vmon;
		logic [31:0] imon;
		logic [31:0] pmon;
		logic [31:0] zcalc;
	} spm_mon_type;
endpackage
`default_nettype wire

// File: spm_lowpass.sv
`default_nettype none
module spm_lowpass #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Control
	input wire logic sample_i,
	input wire logic [31:0] alpha_i,
	// Data
	input wire logic [WIDTH-1:0] data_i,
	output logic [WIDTH-1:0] data_o
);
	logic [31:0] alpha;
	logic signed [WIDTH+33:0] mix;
	// Clamp keeps the pole inside the unit circle
	assign alpha = (alpha_i > spm_pkg::ALPHA_MAX) ? spm_pkg::ALPHA_MAX : alpha_i;
	assign mix = $signed({2'b00, alpha}) * $signed({data_o[WIDTH-1], data_o})
		+ $signed({2'b00, spm_pkg::ALPHA_ONE - alpha}) * $signed({data_i[WIDTH-1], data_i});
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			data_o <= '0;
		end else if (sample_i) begin
			data_o <= mix[WIDTH+spm_pkg::ALPHA_FRAC-1:spm_pkg::ALPHA_FRAC]; // R24
		end
	end
endmodule
`default_nettype wire

// File: spm_bank.sv
// Functional notes
// R01 - Voltage and current setpoint changes are slew limited, analog or digital source.
// R02 - Monitored signals pass through a low-pass filter before output and readback.
// R03 - Each filter is single pole, one alpha, updated at 125 Hz.
// R04 - Readback coefficient governs filtered voltage, current and power.
// R05 - Impedance coefficient governs impedance filtering independently.
// R06 - Expected-unit check enabled by switch 8 or digital interface.
// R07 - With check enabled, too few units discovered raises a fault.
// R08 - With check enabled, full scale follows expected count.
// R09 - Without check, full scale follows discovered count.
// R10 - Non-zero expected count arms fault on count mismatch.
// R11 - Defaults command codes: save, restore saved, restore factory.
// R12 - Shutdown mask bit one makes matching fault shut down the unit.
// R13 - After impedance invalidation wait programmed delay in 8 ms units.
// R14 - Setpoint change above programmed maximum step invalidates impedance.
// R15 - Bus idle timeout counts in 8 ms units.
// R16 - All-ones unlock code locks interface; only correct code unlocks.
// R17 - Voltage quantities use 15-bit fraction, 1.0 is nominal voltage.
// R18 - Current quantities use scale where 1.0 is one unit's current.
// R19 - Power setpoint also serves as process setpoint.
// R20 - Impedance limits use 24-bit fraction, rates 20-bit fraction.
// R21 - Filter coefficients are 24-bit fractions from 0 to 0.9999.
// R22 - Query write requests unit data; device returns it in read registers.
// R23 - 32-bit values are high word then low word in consecutive registers.
// R24 - Filter output is alpha times old plus one minus alpha times input.
// R25 - Each sample moves applied setpoint toward target by at most the limit.
`default_nettype none
module spm_bank #(
	parameter int SAMPLE_CYC = spm_pkg::SAMPLE_CYC,
	parameter logic [31:0] UNLOCK_KEY = 32'h5a5a0001 // arbitrary value
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [5:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// Setpoint sources
	input wire logic analog_sel_i,
	input wire spm_pkg::spm_setpt_type analog_setpt_i,
	// Monitor inputs and units
	input wire spm_pkg::spm_mon_type raw_mon_i,
	input wire logic [7:0] units_found_i,
	input wire logic switch8_up_i,
	input wire logic [31:0] fault_bits_i,
	input wire logic bus_activity_i,
	input wire logic [31:0] factory_code_i,
	// Query response
	input wire logic query_done_i,
	input wire logic [31:0] query_data_i,
	// Outputs
	output spm_pkg::spm_setpt_type applied_setpt_o,
	output spm_pkg::spm_mon_type filt_mon_o,
	output logic [15:0] full_scale_units_o,
	output logic unit_count_fault_o,
	output logic shutdown_o,
	output logic impedance_valid_o,
	output logic bus_timeout_o,
	output logic iface_locked_o,
	output logic [15:0] query_req_o,
	output logic query_req_stb_o,
	output logic save_default_o,
	output logic restore_default_o,
	output logic restore_factory_o
);
	logic [15:0] command_r;
	logic [31:0] vset_r, iset_r, pset_r, ovth_r, zmax_r, zmin_r, zrise_r, zfall_r;
	logic [31:0] fsmask_r, czmax_r, cdrop_r, zimin_r, zalpha_r;
	logic [31:0] vslew_r, islew_r, malpha_r, stepmax_r;
	logic [15:0] expcnt_r, recper_r, zdelay_r, busto_r, hi_hold_r;
	logic [31:0] query_data_r;
	logic [31:0] unlock_r;
	logic [31:0] div_r;
	logic sample;
	logic [15:0] rdata_nxt;
	logic wr_ok;
	logic [31:0] word;
	spm_pkg::spm_setpt_type target;
	spm_pkg::spm_mon_type raw_z;
	logic check_en;
	logic [15:0] zcnt_r, tocnt_r;
	logic [31:0] prev_v_r, prev_i_r;

	// Interface writes ignored while locked, except the unlock pair
	assign wr_ok = wr_i && (!iface_locked_o || addr_i == spm_pkg::OFS_UNLOCK + 6'h01
		|| addr_i == spm_pkg::OFS_UNLOCK);
	assign word = {hi_hold_r, wdata_i};

	function automatic logic lo_hit(input logic [5:0] a, input logic [5:0] base);
		lo_hit = (a == base + 6'h01);
	endfunction

	function automatic logic [31:0] step_toward(input logic [31:0] cur, input logic [31:0] tgt,
		input logic [31:0] lim);
		logic signed [32:0] diff;
		diff = $signed({tgt[31], tgt}) - $signed({cur[31], cur});
		if (diff > $signed({1'b0, lim}))
			step_toward = cur + lim;
		else if (diff < -$signed({1'b0, lim}))
			step_toward = cur - lim;
		else
			step_toward = tgt;
	endfunction

	function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
		abs_diff = ($signed(a) > $signed(b)) ? a - b : b - a;
	endfunction

	// High word held until its low word completes the value
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hi_hold_r <= spm_pkg::RESET_HALF;
		end else if (wr_ok) begin
			hi_hold_r <= wdata_i; // R23
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			command_r <= spm_pkg::RESET_HALF;
			{vset_r, iset_r, pset_r, ovth_r} <= '0;
			{zmax_r, zmin_r, zrise_r, zfall_r} <= '0;
			{fsmask_r, czmax_r, cdrop_r, zimin_r, zalpha_r} <= '0;
			{vslew_r, islew_r, malpha_r, stepmax_r} <= '0;
			{expcnt_r, recper_r, zdelay_r, busto_r} <= '0;
		end else if (wr_ok) begin
			if (addr_i == spm_pkg::OFS_COMMAND) command_r <= wdata_i;
			if (lo_hit(addr_i, spm_pkg::OFS_VSET)) vset_r <= word; // R17
			if (lo_hit(addr_i, spm_pkg::OFS_ISET)) iset_r <= word; // R18
			if (lo_hit(addr_i, spm_pkg::OFS_PSET)) pset_r <= word; // R19
			if (lo_hit(addr_i, spm_pkg::OFS_OVTH)) ovth_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_ZMAX)) zmax_r <= word; // R20
			if (lo_hit(addr_i, spm_pkg::OFS_ZMIN)) zmin_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_ZRISE)) zrise_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_ZFALL)) zfall_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_FSMASK)) fsmask_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_CZMAX)) czmax_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_CDROP)) cdrop_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_ZIMIN)) zimin_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_ZALPHA)) zalpha_r <= word; // R21
			if (addr_i == spm_pkg::OFS_EXPCNT) expcnt_r <= wdata_i;
			if (addr_i == spm_pkg::OFS_RECPER) recper_r <= wdata_i;
			if (lo_hit(addr_i, spm_pkg::OFS_VSLEW)) vslew_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_ISLEW)) islew_r <= word;
			if (lo_hit(addr_i, spm_pkg::OFS_MALPHA)) malpha_r <= word; // R21
			if (lo_hit(addr_i, spm_pkg::OFS_STEPMAX)) stepmax_r <= word;
			if (addr_i == spm_pkg::OFS_ZDELAY) zdelay_r <= wdata_i;
			if (addr_i == spm_pkg::OFS_BUSTO) busto_r <= wdata_i;
		end
	end

	// Lock state; unlock needs the full key
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			unlock_r <= spm_pkg::RESET_WORD;
			iface_locked_o <= 1'b0;
		end else if (wr_ok && lo_hit(addr_i, spm_pkg::OFS_UNLOCK)) begin
			unlock_r <= word;
			if (word == spm_pkg::LOCK_CODE)
				iface_locked_o <= 1'b1; // R16
			else if (word == UNLOCK_KEY)
				iface_locked_o <= 1'b0; // R16
		end
	end

	// One-cycle command pulses
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			save_default_o <= 1'b0;
			restore_default_o <= 1'b0;
			restore_factory_o <= 1'b0;
			query_req_stb_o <= 1'b0;
			query_req_o <= spm_pkg::RESET_HALF;
		end else begin
			save_default_o <= wr_ok && addr_i == spm_pkg::OFS_DEFCMD && wdata_i == spm_pkg::CODE_SAVE; // R11
			restore_default_o <= wr_ok && addr_i == spm_pkg::OFS_DEFCMD
				&& wdata_i == spm_pkg::CODE_RESTORE; // R11
			restore_factory_o <= wr_ok && addr_i == spm_pkg::OFS_DEFCMD
				&& wdata_i == spm_pkg::CODE_FACTORY; // R11
			query_req_stb_o <= wr_ok && addr_i == spm_pkg::OFS_QUERY; // R22
			if (wr_ok && addr_i == spm_pkg::OFS_QUERY)
				query_req_o <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			query_data_r <= spm_pkg::RESET_WORD;
		end else if (query_done_i) begin
			query_data_r <= query_data_i; // R22
		end
	end

	// Sample-rate divider
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_r <= spm_pkg::RESET_WORD;
		end else if (div_r == 32'(SAMPLE_CYC - 1)) begin
			div_r <= spm_pkg::RESET_WORD;
		end else begin
			div_r <= div_r + 32'h00000001;
		end
	end
	assign sample = (div_r == 32'(SAMPLE_CYC - 1)); // R03

	// Limit per 8 ms sample is eight times the per-ms limit
	assign target = analog_sel_i ? analog_setpt_i : {vset_r, iset_r}; // R01
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			applied_setpt_o <= '0;
		end else if (sample) begin
			applied_setpt_o.vset <= step_toward(applied_setpt_o.vset, target.vset, vslew_r << 3); // R01 R25
			applied_setpt_o.iset <= step_toward(applied_setpt_o.iset, target.iset, islew_r << 3); // R01 R25
		end
	end

	// Filters
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_mon
			logic [31:0] raw;
			logic [31:0] filt;
			assign raw = (g == 0) ? raw_mon_i.vmon : (g == 1) ? raw_mon_i.imon : raw_mon_i.pmon;
			spm_lowpass #(.WIDTH(32)) u_lpf (
				.clk_i(clk_i),
				.reset_i(reset_i),
				.sample_i(sample), // R02
				.alpha_i(malpha_r), // R04
				.data_i(raw),
				.data_o(filt)
			);
		end
	endgenerate
	assign filt_mon_o.vmon = g_mon[0].filt;
	assign filt_mon_o.imon = g_mon[1].filt;
	assign filt_mon_o.pmon = g_mon[2].filt;
	assign raw_z = raw_mon_i;
	spm_lowpass #(.WIDTH(32)) u_zlpf (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.sample_i(sample),
		.alpha_i(zalpha_r), // R05
		.data_i(raw_z.zcalc),
		.data_o(filt_mon_o.zcalc)
	);

	// Expected-unit check and analog scale
	assign check_en = switch8_up_i || (expcnt_r != spm_pkg::RESET_HALF); // R06
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			full_scale_units_o <= spm_pkg::RESET_HALF;
			unit_count_fault_o <= 1'b0;
		end else begin
			full_scale_units_o <= check_en ? expcnt_r : {8'h00, units_found_i}; // R08 R09
			unit_count_fault_o <= check_en && ({8'h00, units_found_i} < expcnt_r
				|| (expcnt_r != spm_pkg::RESET_HALF && {8'h00, units_found_i} != expcnt_r)); // R07 R10
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			shutdown_o <= 1'b0;
		end else begin
			shutdown_o <= |(fault_bits_i & fsmask_r); // R12
		end
	end

	// Impedance validity; each sample tick is one 8 ms unit
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_v_r <= spm_pkg::RESET_WORD;
			prev_i_r <= spm_pkg::RESET_WORD;
			zcnt_r <= spm_pkg::RESET_HALF;
			impedance_valid_o <= 1'b0;
		end else if (sample) begin
			prev_v_r <= target.vset;
			prev_i_r <= target.iset;
			if (abs_diff(target.vset, prev_v_r) > stepmax_r || abs_diff(target.iset, prev_i_r) > stepmax_r) begin
				zcnt_r <= zdelay_r; // R14
				impedance_valid_o <= 1'b0; // R14
			end else if (zcnt_r > 16'h0001) begin
				zcnt_r <= zcnt_r - 16'h0001; // R13
			end else begin
				// Valid on the last delay unit, not one sample later
				zcnt_r <= spm_pkg::RESET_HALF;
				impedance_valid_o <= 1'b1; // R13
			end
		end
	end

	// Bus idle timeout, enabled by command bit 5
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tocnt_r <= spm_pkg::RESET_HALF;
			bus_timeout_o <= 1'b0;
		end else if (bus_activity_i || wr_i || rd_i || !command_r[5]) begin
			tocnt_r <= spm_pkg::RESET_HALF;
			bus_timeout_o <= 1'b0;
		end else if (sample && !bus_timeout_o) begin
			if (tocnt_r + 16'h0001 >= busto_r && busto_r != spm_pkg::RESET_HALF)
				bus_timeout_o <= 1'b1; // R15
			tocnt_r <= tocnt_r + 16'h0001; // R15
		end
	end

	always_comb begin
		rdata_nxt = 16'h0000;
		case (addr_i)
			spm_pkg::OFS_STATUS: rdata_nxt = {10'h000, iface_locked_o, bus_timeout_o,
				impedance_valid_o, shutdown_o, unit_count_fault_o, check_en};
			spm_pkg::OFS_VMON: rdata_nxt = filt_mon_o.vmon[31:16];
			spm_pkg::OFS_VMON + 6'h01: rdata_nxt = filt_mon_o.vmon[15:0];
			spm_pkg::OFS_IMON: rdata_nxt = filt_mon_o.imon[31:16];
			spm_pkg::OFS_IMON + 6'h01: rdata_nxt = filt_mon_o.imon[15:0];
			spm_pkg::OFS_PMON: rdata_nxt = filt_mon_o.pmon[31:16];
			spm_pkg::OFS_PMON + 6'h01: rdata_nxt = filt_mon_o.pmon[15:0];
			spm_pkg::OFS_ZMON: rdata_nxt = filt_mon_o.zcalc[31:16];
			spm_pkg::OFS_ZMON + 6'h01: rdata_nxt = filt_mon_o.zcalc[15:0];
			spm_pkg::OFS_VAPP: rdata_nxt = applied_setpt_o.vset[31:16];
			spm_pkg::OFS_VAPP + 6'h01: rdata_nxt = applied_setpt_o.vset[15:0];
			spm_pkg::OFS_IAPP: rdata_nxt = applied_setpt_o.iset[31:16];
			spm_pkg::OFS_IAPP + 6'h01: rdata_nxt = applied_setpt_o.iset[15:0];
			spm_pkg::OFS_FSCALE: rdata_nxt = full_scale_units_o;
			spm_pkg::OFS_QUERY: rdata_nxt = query_data_r[31:16];
			spm_pkg::OFS_QUERY + 6'h01: rdata_nxt = query_data_r[15:0];
			default: rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= spm_pkg::RESET_HALF;
		end else if (rd_i) begin
			rdata_o <= rdata_nxt;
		end else begin
			rdata_o <= spm_pkg::RESET_HALF;
		end
	end
endmodule
`default_nettype wire

// File: spm_host.sv
`default_nettype none
module spm_host (
	// Register port, master side
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output logic [5:0] addr_o,
	output logic [15:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr_o = 6'h00;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr16(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// Stale data would hide a late capture
		wdata_o <= ~d;
	endtask
	task automatic wr32(input logic [5:0] a, input logic [31:0] d);
		wr16(a, d[31:16]);
		wr16(a + 6'h01, d[15:0]);
	endtask
	task automatic rd16(input logic [5:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
endmodule
`default_nettype wire

// File: spm_bank_asserts.sv
`default_nettype none
module spm_bank_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [5:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	// Watched outputs
	input wire logic iface_locked_o,
	input wire logic [15:0] query_req_o,
	input wire logic query_req_stb_o,
	input wire logic save_default_o,
	input wire logic restore_default_o,
	input wire logic restore_factory_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic def_w;
	logic fac_w;
	assign def_w = wr_i && !iface_locked_o && addr_i == 6'h1b;
	// Back-to-back factory writes keep the pulse up
	assign fac_w = def_w && wdata_i == 16'h9abc;
	save_cmd_a: assert property (def_w && wdata_i == spm_pkg::CODE_SAVE |=> save_default_o)
		else $error("save pulse missing");
	restore_cmd_a: assert property (def_w && wdata_i == 16'h5678 |=> restore_default_o && !save_default_o)
		else $error("restore pulse wrong");
	factory_cmd_a: assert property (fac_w |=> restore_factory_o ##1 (!restore_factory_o || $past(fac_w)))
		else $error("factory pulse wrong");
	query_pulse_a: assert property (query_req_stb_o |-> query_req_o == $past(wdata_i) && $past(wr_i))
		else $error("query request wrong");
	read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data outside slot");
	unmapped_rd_a: assert property (rd_i && addr_i == 6'h2f |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	status_lock_a: assert property (rd_i && addr_i == 6'h30 |=> rdata_o[5] == $past(iface_locked_o))
		else $error("status lock bit wrong");
	lock_hold_a: assert property (iface_locked_o && !(wr_i && addr_i inside {6'h29, 6'h2a}) |=> iface_locked_o)
		else $error("lock dropped");
endmodule
bind spm_bank spm_bank_asserts spm_bank_asserts_inst (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .iface_locked_o(iface_locked_o),
	.query_req_o(query_req_o), .query_req_stb_o(query_req_stb_o), .save_default_o(save_default_o),
	.restore_default_o(restore_default_o), .restore_factory_o(restore_factory_o));
`default_nettype wire

// File: spm_bank_bench.sv
`default_nettype none
module spm_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 16;
	localparam int LIM = 2 * SC + 4;
	localparam logic [31:0] KEY = 32'h5a5a0001; // arbitrary value
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [5:0] addr_i;
	logic [15:0] wdata_i;
	logic [15:0] rdata_o;
	logic wr_i;
	logic rd_i;
	spm_pkg::spm_setpt_type ap;
	spm_pkg::spm_setpt_type aset = '0;
	logic asel = 1'b0;
	spm_pkg::spm_mon_type raw = '0;
	spm_pkg::spm_mon_type flt;
	logic [7:0] units = 8'h00;
	logic sw8 = 1'b0;
	logic act = 1'b1;
	logic qdone = 1'b0;
	logic [31:0] fbits = 32'h0;
	logic [31:0] qdata = 32'h0;
	logic [15:0] fs;
	logic [15:0] qreq;
	logic [15:0] v;
	logic cf, sd, zv, bt, lk, qs, sv, rs, rf;
	int n_mismatch = 0;
	int comparisons = 0;
	always #12.5 clk_i = ~clk_i;
	spm_bank #(.SAMPLE_CYC(SC), .UNLOCK_KEY(KEY)) spm_bank_inst (.clk_i(clk_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.analog_sel_i(asel), .analog_setpt_i(aset), .raw_mon_i(raw), .units_found_i(units),
		.switch8_up_i(sw8), .fault_bits_i(fbits), .bus_activity_i(act), .factory_code_i(32'h0),
		.query_done_i(qdone), .query_data_i(qdata), .applied_setpt_o(ap), .filt_mon_o(flt),
		.full_scale_units_o(fs), .unit_count_fault_o(cf), .shutdown_o(sd), .impedance_valid_o(zv),
		.bus_timeout_o(bt), .iface_locked_o(lk), .query_req_o(qreq), .query_req_stb_o(qs),
		.save_default_o(sv), .restore_default_o(rs), .restore_factory_o(rf));
	spm_host h (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic expire();
		n_mismatch++;
		test_done();
	endtask
	// Covers any sample phase, so level outputs are settled
	task automatic settle();
		repeat (LIM) @(posedge clk_i);
		#1;
	endtask
	task automatic test_defaults();
		logic [15:0] c [3];
		c = '{16'h1234, 16'h5678, 16'h9abc};
		for (int i = 0; i < 3; i++) begin
			h.wr16(6'h1b, c[i]);
			#1 chk("pulses", 32'(3'b100 >> i), {29'h0, sv, rs, rf});
			@(posedge clk_i);
			#1 chk("pulse end", 32'h0, {29'h0, sv, rs, rf});
		end
	endtask
	task automatic test_slew();
		logic [31:0] p, s, top;
		top = 32'h0;
		h.wr32(6'h1f, 32'h00001000);
		h.wr32(6'h01, 32'h00010000);
		p = ap.vset;
		repeat (4 * SC + 8) begin
			@(posedge clk_i);
			#1 s = ap.vset - p;
			p = ap.vset;
			if (s > top) top = s;
		end
		chk("largest step", 32'h00008000, top);
		chk("applied voltage", 32'h00010000, ap.vset);
	endtask
	// Analog target takes over from the digital one, still slew limited
	task automatic test_analog();
		int n;
		@(posedge clk_i);
		asel <= 1'b1;
		n = 0;
		while (ap.vset === 32'h00010000 && n < LIM) begin
			@(posedge clk_i);
			#1 n++;
		end
		if (n >= LIM) expire();
		chk("analog step", 32'h00008000, ap.vset);
		settle();
		chk("analog target", 32'h00000000, ap.vset);
	endtask
	task automatic test_impedance();
		int n;
		h.wr32(6'h25, 32'h00001000);
		h.wr16(6'h27, 16'h0002);
		@(posedge clk_i);
		aset.vset <= 32'h00004000;
		n = 0;
		while (zv === 1'b1 && n < LIM) begin
			@(posedge clk_i);
			#1 n++;
		end
		if (n >= LIM) expire();
		repeat (2 * SC - 1) @(posedge clk_i);
		#1 chk("impedance held", 32'h0, 32'(zv));
		@(posedge clk_i);
		#1 chk("impedance valid", 32'h1, 32'(zv));
	endtask
	task automatic test_filter();
		int n;
		h.wr32(6'h23, 32'h00800000);
		h.wr32(6'h19, 32'h00000000);
		settle();
		@(posedge clk_i);
		raw.vmon <= 32'h1000;
		raw.zcalc <= 32'h1000;
		raw.imon <= 32'h2000;
		raw.pmon <= 32'h0400;
		n = 0;
		while (flt.vmon === 32'h0 && n < LIM) begin
			@(posedge clk_i);
			#1 n++;
		end
		if (n >= LIM) expire();
		chk("filtered voltage", 32'h00000800, flt.vmon);
		chk("filtered current", 32'h00001000, flt.imon);
		chk("filtered power", 32'h00000200, flt.pmon);
		chk("impedance", 32'h00001000, flt.zcalc);
		repeat (SC) @(posedge clk_i);
		#1 chk("filtered voltage 2", 32'h00000c00, flt.vmon);
	endtask
	task automatic test_units();
		@(posedge clk_i);
		units <= 8'h03;
		sw8 <= 1'b1;
		h.wr16(6'h1d, 16'h0006);
		settle();
		chk("count fault", 32'h1, 32'(cf));
		chk("scale expected", 32'h6, 32'(fs));
		@(posedge clk_i);
		sw8 <= 1'b0;
		h.wr16(6'h1d, 16'h0000);
		settle();
		chk("count fault off", 32'h0, 32'(cf));
		chk("scale found", 32'h3, 32'(fs));
	endtask
	task automatic test_shutdown();
		@(posedge clk_i);
		fbits <= 32'h00000008;
		h.wr32(6'h11, 32'h00000010);
		settle();
		chk("report only", 32'h0, 32'(sd));
		h.wr32(6'h11, 32'h00000008);
		settle();
		chk("shutdown", 32'h1, 32'(sd));
	endtask
	task automatic test_timeout();
		@(posedge clk_i);
		act <= 1'b0;
		h.wr16(6'h28, 16'h0002);
		h.wr16(6'h00, 16'h0020);
		repeat (SC) @(posedge clk_i);
		#1 chk("timeout early", 32'h0, 32'(bt));
		repeat (3 * SC) @(posedge clk_i);
		#1 chk("timeout", 32'h1, 32'(bt));
	endtask
	task automatic test_query();
		h.wr16(6'h1c, 16'h0203);
		#1 chk("query request", 32'h00010203, {15'h0, qs, qreq});
		@(posedge clk_i);
		qdata <= 32'h1234abcd;
		qdone <= 1'b1;
		@(posedge clk_i);
		qdone <= 1'b0;
		h.rd16(6'h1c, v);
		chk("query high", 32'h1234, 32'(v));
		h.rd16(6'h1d, v);
		chk("query low", 32'habcd, 32'(v));
		h.rd16(6'h2f, v);
		chk("unmapped", 32'h0, 32'(v));
	endtask
	task automatic test_lock();
		h.wr32(6'h29, spm_pkg::LOCK_CODE);
		h.rd16(6'h30, v);
		chk("lock status", 32'h1, 32'(v[5]));
		h.wr16(6'h1b, 16'h1234);
		#1 chk("locked write", 32'h0, 32'(sv));
		h.wr32(6'h29, 32'h00000001);
		settle();
		chk("wrong code", 32'h1, 32'(lk));
		h.wr32(6'h29, KEY);
		settle();
		chk("unlocked", 32'h0, 32'(lk));
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		test_defaults();
		test_slew();
		test_analog();
		test_impedance();
		test_filter();
		test_units();
		test_shutdown();
		test_query();
		test_lock();
		test_timeout();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		expire();
	end
endmodule
`default_nettype wire
